// ==== rtl/lccd_decoder.sv ====
// Command decoder for the dot-matrix LCD control registers.
`default_nettype none
module lccd_decoder (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // Host bus pins, asynchronous to CORE_CLK
  input wire logic [7:0] HOST_DB,
  input wire logic CMD_DATA_SELECT,
  input wire logic HOST_WR_N,
  input wire logic HOST_RD_N,
  // Display memory access
  output logic [7:0] COLUMN_ADDR,
  output logic [3:0] PAGE_ADDR,
  output logic [5:0] START_LINE,
  output logic DATA_WR_STB,
  output logic [7:0] DATA_WR_BYTE,
  output logic DATA_RD_STB,
  // Control register outputs
  output logic COMMON_SCAN_REVERSE,
  output logic [2:0] POWER_CIRCUIT_ENABLES,
  output logic [2:0] DRIVE_VOLTAGE_RATIO,
  output logic [5:0] CONTRAST_LEVEL,
  output logic [1:0] INDICATOR_BLINK_MODE,
  output logic LINE_REVERSAL_ON,
  output logic [4:0] LINE_INVERSION_COUNT,
  // Status
  output logic RMW_ACTIVE,
  output logic TEST_MODE,
  output logic SECOND_BYTE_PENDING
);
  // ==========================================================
  // Host interface
  logic [7:0] byte_s;
  logic sel_s;
  logic wr_s;
  logic rd_s;

  lccd_host_sync #(
    .W(lccd_pkg::BYTE_W)
  ) u_sync (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .db_pin(HOST_DB),
    .sel_pin(CMD_DATA_SELECT),
    .wr_n_pin(HOST_WR_N),
    .rd_n_pin(HOST_RD_N),
    .byte_o(byte_s),
    .sel_o(sel_s),
    .wr_stb(wr_s),
    .rd_stb(rd_s)
  );

  // ==========================================================
  // Strobe classification
  logic cmd_wr;
  logic dat_wr;
  logic dat_rd;
  assign cmd_wr = wr_s & ~sel_s;
  assign dat_wr = wr_s & sel_s;
  assign dat_rd = rd_s & sel_s;

  lccd_pkg::lccd_wait_t wait_r;
  logic idle_cmd;
  assign idle_cmd = cmd_wr & (wait_r == lccd_pkg::LCCD_IDLE);

  // ==========================================================
  // Command decode, valid only outside a second-byte wait
  logic is_rmw, is_end, is_srst, is_nop, is_test;
  logic is_line, is_page, is_col_hi, is_col_lo, is_comdir;
  logic is_power, is_ratio, is_contrast, is_ind_off, is_ind_on;
  logic is_frame, is_linerev;

  always_comb begin
    is_rmw = idle_cmd & (byte_s == lccd_pkg::CMD_RMW);
    is_end = idle_cmd & (byte_s == lccd_pkg::CMD_END);
    is_srst = idle_cmd & (byte_s == lccd_pkg::CMD_SOFT_RESET);
    is_nop = idle_cmd & (byte_s == lccd_pkg::CMD_NOP);
    is_contrast = idle_cmd & (byte_s == lccd_pkg::CMD_CONTRAST);
    is_ind_off = idle_cmd & (byte_s == lccd_pkg::CMD_IND_OFF);
    is_ind_on = idle_cmd & (byte_s == lccd_pkg::CMD_IND_ON);
    is_test = idle_cmd &
      ((byte_s & lccd_pkg::MSK_NIB) == lccd_pkg::PFX_TEST);
    is_line = idle_cmd &
      ((byte_s & lccd_pkg::MSK_LINE) == lccd_pkg::PFX_LINE);
    is_page = idle_cmd &
      ((byte_s & lccd_pkg::MSK_NIB) == lccd_pkg::PFX_PAGE);
    is_col_hi = idle_cmd &
      ((byte_s & lccd_pkg::MSK_NIB) == lccd_pkg::PFX_COL_HI);
    is_col_lo = idle_cmd &
      ((byte_s & lccd_pkg::MSK_NIB) == lccd_pkg::PFX_COL_LO);
    is_comdir = idle_cmd &
      ((byte_s & lccd_pkg::MSK_NIB) == lccd_pkg::PFX_COMDIR);
    is_power = idle_cmd &
      ((byte_s & lccd_pkg::MSK_3LOW) == lccd_pkg::PFX_POWER);
    is_ratio = idle_cmd &
      ((byte_s & lccd_pkg::MSK_3LOW) == lccd_pkg::PFX_RATIO);
    is_frame = idle_cmd &
      ((byte_s & lccd_pkg::MSK_3LOW) == lccd_pkg::PFX_FRAME);
    is_linerev = idle_cmd &
      ((byte_s & lccd_pkg::MSK_3LOW) == lccd_pkg::PFX_LINEREV);
  end

  // ==========================================================
  // Second-byte lock-out
  // Any command-phase byte in a wait state is the value byte,
  // so a stray reset code here cannot break the pair.
  lccd_pkg::lccd_wait_t wait_nxt;
  always_comb begin
    wait_nxt = wait_r;
    case (wait_r)
      lccd_pkg::LCCD_IDLE: begin
        if (is_contrast) begin
          wait_nxt = lccd_pkg::LCCD_WAIT_CONTRAST;
        end else if (is_ind_on) begin
          wait_nxt = lccd_pkg::LCCD_WAIT_INDICATOR;
        end else if (is_linerev) begin
          wait_nxt = lccd_pkg::LCCD_WAIT_LINECNT;
        end
      end
      lccd_pkg::LCCD_WAIT_CONTRAST,
      lccd_pkg::LCCD_WAIT_INDICATOR,
      lccd_pkg::LCCD_WAIT_LINECNT: begin
        if (cmd_wr) begin
          wait_nxt = lccd_pkg::LCCD_IDLE;
        end
      end
      default: wait_nxt = lccd_pkg::LCCD_IDLE;
    endcase
  end

  // Wait state register; hardware reset is the only full init
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wait_r <= lccd_pkg::LCCD_IDLE;
    end else begin
      wait_r <= wait_nxt;
    end
  end
  assign SECOND_BYTE_PENDING = (wait_r != lccd_pkg::LCCD_IDLE);
  logic val_contrast, val_ind, val_linecnt;
  assign val_contrast = cmd_wr & (wait_r == lccd_pkg::LCCD_WAIT_CONTRAST);
  assign val_ind = cmd_wr & (wait_r == lccd_pkg::LCCD_WAIT_INDICATOR);
  assign val_linecnt = cmd_wr & (wait_r == lccd_pkg::LCCD_WAIT_LINECNT);

  // ==========================================================
  // Column address with read-modify-write
  logic [7:0] col_r, col_nxt, col_save_r;
  logic rmw_r;
  logic col_step;
  // Reads only advance outside read-modify-write
  assign col_step = dat_wr | (dat_rd & ~rmw_r);
  always_comb begin
    col_nxt = col_r;
    if (is_srst) begin
      col_nxt = lccd_pkg::COL_RST;
    end else if (is_end && rmw_r) begin
      col_nxt = col_save_r;
    end else if (is_col_hi) begin
      col_nxt = {byte_s[3:0], col_r[3:0]};
    end else if (is_col_lo) begin
      col_nxt = {col_r[7:4], byte_s[3:0]};
    end else if (col_step && col_r != lccd_pkg::COL_LAST) begin
      col_nxt = col_r + 8'h01;
    end
  end

  // Column register
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      col_r <= lccd_pkg::COL_RST;
    end else begin
      col_r <= col_nxt;
    end
  end

  // Mode flag and saved column; re-issuing the mode re-saves
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rmw_r <= 1'b0;
      col_save_r <= lccd_pkg::COL_RST;
    end else begin
      if (is_rmw) begin
        rmw_r <= 1'b1;
        col_save_r <= col_r;
      end else if (is_end || is_srst) begin
        rmw_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Page and start line
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PAGE_ADDR <= lccd_pkg::PAGE_RST;
      START_LINE <= lccd_pkg::LINE_RST;
    end else begin
      if (is_srst) begin
        PAGE_ADDR <= lccd_pkg::PAGE_RST;
        START_LINE <= lccd_pkg::LINE_RST;
      end else begin
        // Nonexistent pages are ignored rather than aliased
        if (is_page && byte_s[3:0] <= lccd_pkg::PAGE_LAST) begin
          PAGE_ADDR <= byte_s[3:0];
        end
        if (is_line) begin
          START_LINE <= byte_s[5:0];
        end
      end
    end
  end

  // ==========================================================
  // Scan direction, ratio and contrast (soft reset applies)
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      COMMON_SCAN_REVERSE <= 1'b0;
      DRIVE_VOLTAGE_RATIO <= lccd_pkg::RATIO_RST;
      CONTRAST_LEVEL <= lccd_pkg::CONTRAST_RST;
    end else if (is_srst) begin
      COMMON_SCAN_REVERSE <= 1'b0;
      DRIVE_VOLTAGE_RATIO <= lccd_pkg::RATIO_RST;
      CONTRAST_LEVEL <= lccd_pkg::CONTRAST_RST;
    end else begin
      if (is_comdir) begin
        COMMON_SCAN_REVERSE <= byte_s[lccd_pkg::COMDIR_BIT];
      end
      // The inhibited code is dropped so the ratio stays legal
      if (is_ratio && byte_s[2:0] != lccd_pkg::RATIO_INHIBIT) begin
        DRIVE_VOLTAGE_RATIO <= byte_s[2:0];
      end
      if (val_contrast) begin
        CONTRAST_LEVEL <= byte_s[5:0];
      end
    end
  end

  // ==========================================================
  // Static indicator
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      INDICATOR_BLINK_MODE <= lccd_pkg::INDICATOR_RST;
    end else if (is_srst || is_ind_off) begin
      INDICATOR_BLINK_MODE <= lccd_pkg::INDICATOR_RST;
    end else if (val_ind) begin
      INDICATOR_BLINK_MODE <= byte_s[1:0];
    end
  end

  // ==========================================================
  // Power enables and drive method: soft reset leaves them
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      POWER_CIRCUIT_ENABLES <= lccd_pkg::POWER_RST;
      LINE_REVERSAL_ON <= 1'b0;
      LINE_INVERSION_COUNT <= lccd_pkg::LINECNT_RST;
    end else begin
      if (is_power) begin
        POWER_CIRCUIT_ENABLES <= byte_s[2:0];
      end
      if (is_frame) begin
        LINE_REVERSAL_ON <= 1'b0;
      end else if (is_linerev) begin
        LINE_REVERSAL_ON <= 1'b1;
      end
      if (val_linecnt) begin
        LINE_INVERSION_COUNT <= byte_s[4:0];
      end
    end
  end

  // ==========================================================
  // Factory test mode: only NOP or soft reset release it
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      TEST_MODE <= 1'b0;
    end else if (is_srst || is_nop) begin
      TEST_MODE <= 1'b0;
    end else if (is_test) begin
      TEST_MODE <= 1'b1;
    end
  end

  // ==========================================================
  // Display data strobes; memory itself lives outside and no
  // command here drives it, so soft reset keeps its contents
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      DATA_WR_STB <= 1'b0;
      DATA_RD_STB <= 1'b0;
      DATA_WR_BYTE <= 8'h00;
    end else begin
      DATA_WR_STB <= dat_wr;
      DATA_RD_STB <= dat_rd;
      if (dat_wr) begin
        DATA_WR_BYTE <= byte_s;
      end
    end
  end

  // Address out is the pre-advance column of each access
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      COLUMN_ADDR <= lccd_pkg::COL_RST;
    end else if (dat_wr || dat_rd) begin
      COLUMN_ADDR <= col_r;
    end else begin
      COLUMN_ADDR <= col_nxt;
    end
  end
  assign RMW_ACTIVE = rmw_r;
endmodule
`default_nettype wire

// ==== rtl/lccd_pkg.sv ====
// Constants shared by the LCD control command decoder.
`default_nettype none
package lccd_pkg;
  // ==========================================================
  // Widths and limits
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned COL_W = 8;
  localparam int unsigned PAGE_W = 4;
  localparam int unsigned LINE_W = 6;
  localparam logic [7:0] COL_LAST = 8'h83;
  localparam logic [3:0] PAGE_LAST = 4'h8;
  localparam logic [2:0] RATIO_INHIBIT = 3'h7;
  // ==========================================================
  // Values after reset
  localparam logic [7:0] COL_RST = 8'h00;
  localparam logic [3:0] PAGE_RST = 4'h0;
  localparam logic [5:0] LINE_RST = 6'h00;
  localparam logic [2:0] POWER_RST = 3'h0;
  localparam logic [2:0] RATIO_RST = 3'h4;
  localparam logic [5:0] CONTRAST_RST = 6'h20;
  localparam logic [1:0] INDICATOR_RST = 2'h0;
  localparam logic [4:0] LINECNT_RST = 5'h10;
  // ==========================================================
  // Single command codes
  localparam logic [7:0] CMD_RMW = 8'he0;
  localparam logic [7:0] CMD_END = 8'hee;
  localparam logic [7:0] CMD_SOFT_RESET = 8'he2;
  localparam logic [7:0] CMD_NOP = 8'he3;
  localparam logic [7:0] CMD_CONTRAST = 8'h81;
  localparam logic [7:0] CMD_IND_OFF = 8'hac;
  localparam logic [7:0] CMD_IND_ON = 8'had;
  // ==========================================================
  // Command groups: masked prefix match
  localparam logic [7:0] MSK_LINE = 8'hc0;
  localparam logic [7:0] PFX_LINE = 8'h40;
  localparam logic [7:0] MSK_NIB = 8'hf0;
  localparam logic [7:0] PFX_PAGE = 8'hb0;
  localparam logic [7:0] PFX_COL_HI = 8'h10;
  localparam logic [7:0] PFX_COL_LO = 8'h00;
  localparam logic [7:0] PFX_COMDIR = 8'hc0;
  localparam logic [7:0] PFX_TEST = 8'hf0;
  localparam logic [7:0] MSK_3LOW = 8'hf8;
  localparam logic [7:0] PFX_POWER = 8'h28;
  localparam logic [7:0] PFX_RATIO = 8'h20;
  localparam logic [7:0] PFX_FRAME = 8'hd0;
  localparam logic [7:0] PFX_LINEREV = 8'hd8;
  // ==========================================================
  // Field positions
  localparam int unsigned COMDIR_BIT = 3;
  // ==========================================================
  // Second-byte wait states
  typedef enum logic [1:0] {
    LCCD_IDLE,
    LCCD_WAIT_CONTRAST,
    LCCD_WAIT_INDICATOR,
    LCCD_WAIT_LINECNT
  } lccd_wait_t;
endpackage
`default_nettype wire

// ==== rtl/lccd_host_sync.sv ====
// Host pin synchroniser and strobe edge detector.
`default_nettype none
module lccd_host_sync #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous host pins
  input wire logic [W-1:0] db_pin,
  input wire logic sel_pin,
  input wire logic wr_n_pin,
  input wire logic rd_n_pin,
  // Synchronised results
  output logic [W-1:0] byte_o,
  output logic sel_o,
  output logic wr_stb,
  output logic rd_stb
);
  logic [W+2:0] meta_r;
  logic [W+2:0] sync_r;
  logic wr_n_d_r;
  logic rd_n_d_r;

  // Two flops per pin; only sync_r ever reads meta_r
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= {rd_n_pin, wr_n_pin, sel_pin, db_pin};
      sync_r <= meta_r;
    end
  end

  // Strobes fire on the trailing edge, when the bus is settled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_n_d_r <= 1'b1;
      rd_n_d_r <= 1'b1;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      byte_o <= '0;
      sel_o <= 1'b0;
    end else begin
      wr_n_d_r <= sync_r[W+1];
      rd_n_d_r <= sync_r[W+2];
      wr_stb <= sync_r[W+1] & ~wr_n_d_r;
      rd_stb <= sync_r[W+2] & ~rd_n_d_r;
      byte_o <= sync_r[W-1:0];
      sel_o <= sync_r[W];
    end
  end
endmodule
`default_nettype wire

// ==== sim/lccd_host_model.sv ====
// Host processor model driving the parallel command pins.
`default_nettype none
module lccd_host_model (
  // Clock
  input wire logic clk,
  // Host pins
  output logic [7:0] db,
  output logic sel,
  output logic wr_n,
  output logic rd_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // Idle pins at time zero
  initial begin
    db = 8'h00;
    sel = 1'b0;
    wr_n = 1'b1;
    rd_n = 1'b1;
  end
  // Strobe low and high 4 cycles each, one above the minimum
  task automatic wr(input logic s, input logic [7:0] d);
    @(negedge clk);
    sel = s;
    db = d;
    wr_n = 1'b0;
    repeat (4) @(negedge clk);
    wr_n = 1'b1;
    repeat (4) @(negedge clk);
    db = ~d; // Stale byte must not linger on the bus
  endtask
  // Display data read; the bus is the device's during the pulse
  task automatic rd();
    @(negedge clk);
    sel = 1'b1;
    db = ~db;
    rd_n = 1'b0;
    repeat (4) @(negedge clk);
    rd_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ==== sim/lccd_decoder_asserts.sv ====
// Port checker for the LCD control command decoder.
`default_nettype none
module lccd_decoder_asserts (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // Watched outputs
  input wire logic [7:0] COLUMN_ADDR,
  input wire logic DATA_WR_STB,
  input wire logic DATA_RD_STB,
  input wire logic COMMON_SCAN_REVERSE,
  input wire logic [2:0] POWER_CIRCUIT_ENABLES,
  input wire logic [2:0] DRIVE_VOLTAGE_RATIO,
  input wire logic [5:0] CONTRAST_LEVEL,
  input wire logic LINE_REVERSAL_ON,
  input wire logic [4:0] LINE_INVERSION_COUNT,
  input wire logic RMW_ACTIVE,
  input wire logic SECOND_BYTE_PENDING
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  logic [7:0] saved_r;
  // ====
  // Column held when the mode starts, the restore target
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN)
      saved_r <= 8'h00;
    else if ($rose(RMW_ACTIVE))
      saved_r <= COLUMN_ADDR;
  end
  // ====
  // Assertions
  reset_vals_a: assert property ($rose(RSTN) |->
    DRIVE_VOLTAGE_RATIO == 3'h4 && CONTRAST_LEVEL == 6'h20)
    else $error("ratio or contrast wrong after reset");
  ratio_legal_a: assert property (DRIVE_VOLTAGE_RATIO != 3'h7)
    else $error("inhibited ratio code loaded");
  col_step_a: assert property (DATA_WR_STB && COLUMN_ADDR < 8'h83
    |=> COLUMN_ADDR == $past(COLUMN_ADDR) + 8'h01)
    else $error("column did not advance on write");
  col_stop_a: assert property (DATA_WR_STB && COLUMN_ADDR == 8'h83
    |=> COLUMN_ADDR == 8'h83) else $error("column passed last");
  rmw_read_a: assert property (DATA_RD_STB && RMW_ACTIVE
    |=> $stable(COLUMN_ADDR)) else $error("column moved on rmw read");
  wr_pulse_a: assert property (DATA_WR_STB |=> !DATA_WR_STB)
    else $error("data strobe longer than one cycle");
  wait_guard_a: assert property ($changed(POWER_CIRCUIT_ENABLES) ||
    $changed(COMMON_SCAN_REVERSE) |-> !$past(SECOND_BYTE_PENDING))
    else $error("command decoded while value byte pending");
  count_load_a: assert property ($changed(LINE_INVERSION_COUNT)
    |-> $past(SECOND_BYTE_PENDING) && !SECOND_BYTE_PENDING &&
    LINE_REVERSAL_ON) else $error("line count loaded outside wait");
  rmw_restore_a: assert property ($fell(RMW_ACTIVE)
    |-> COLUMN_ADDR == saved_r || COLUMN_ADDR == 8'h00)
    else $error("column not restored at mode end");
endmodule
bind lccd_decoder lccd_decoder_asserts chk (.CORE_CLK(CORE_CLK),
  .RSTN(RSTN), .COLUMN_ADDR(COLUMN_ADDR), .DATA_WR_STB(DATA_WR_STB),
  .DATA_RD_STB(DATA_RD_STB), .COMMON_SCAN_REVERSE(COMMON_SCAN_REVERSE),
  .POWER_CIRCUIT_ENABLES(POWER_CIRCUIT_ENABLES),
  .DRIVE_VOLTAGE_RATIO(DRIVE_VOLTAGE_RATIO),
  .CONTRAST_LEVEL(CONTRAST_LEVEL), .LINE_REVERSAL_ON(LINE_REVERSAL_ON),
  .LINE_INVERSION_COUNT(LINE_INVERSION_COUNT), .RMW_ACTIVE(RMW_ACTIVE),
  .SECOND_BYTE_PENDING(SECOND_BYTE_PENDING));
`default_nettype wire

// ==== sim/tb_lccd_decoder.sv ====
// Self-checking bench for the LCD control command decoder.
`default_nettype none
module tb_lccd_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] db;
  logic sel, wr_n, rd_n, wstb, rstb, scn, lrv, rmw, tst, pnd;
  logic [7:0] col, wbyte;
  logic [3:0] pag;
  logic [5:0] sln, con;
  logic [2:0] pwr, rat;
  logic [1:0] ind;
  logic [4:0] lcnt;
  int err_total = 0;
  int n_checks = 0;
  // ====
  // Clock at 50 MHz
  initial begin
    forever #10 clk = ~clk;
  end
  lccd_host_model host (.clk(clk), .db(db), .sel(sel), .wr_n(wr_n),
    .rd_n(rd_n));
  lccd_decoder dut (.CORE_CLK(clk), .RSTN(rst_n), .HOST_DB(db),
    .CMD_DATA_SELECT(sel), .HOST_WR_N(wr_n), .HOST_RD_N(rd_n),
    .COLUMN_ADDR(col), .PAGE_ADDR(pag), .START_LINE(sln),
    .DATA_WR_STB(wstb), .DATA_WR_BYTE(wbyte), .DATA_RD_STB(rstb),
    .COMMON_SCAN_REVERSE(scn), .POWER_CIRCUIT_ENABLES(pwr),
    .DRIVE_VOLTAGE_RATIO(rat), .CONTRAST_LEVEL(con),
    .INDICATOR_BLINK_MODE(ind), .LINE_REVERSAL_ON(lrv),
    .LINE_INVERSION_COUNT(lcnt), .RMW_ACTIVE(rmw), .TEST_MODE(tst),
    .SECOND_BYTE_PENDING(pnd));
  // ====
  // Helpers; two extra cycles cover the pin phase slack
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    host.wr(1'b0, b);
    repeat (2) @(negedge clk);
  endtask
  task automatic dat(input logic [7:0] b);
    host.wr(1'b1, b);
    repeat (2) @(negedge clk);
  endtask
  task automatic rdd();
    host.rd();
    repeat (2) @(negedge clk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ====
  // Scenarios
  task automatic hw_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("ratio", 8'h04, 8'(rat));
    chk("contrast", 8'h20, 8'(con));
    chk("power", 8'h00, 8'(pwr));
    chk("count", 8'h10, 8'(lcnt));
    chk("linerev", 8'h00, 8'(lrv));
  endtask
  task automatic t_power_ratio();
    for (int i = 0; i < 8; i++) begin
      cmd(8'h28 | 8'(i));
      chk("power", 8'(i), 8'(pwr));
    end
    for (int i = 0; i < 7; i++) begin
      cmd(8'h20 | 8'(i));
      chk("ratio", 8'(i), 8'(rat));
    end
    cmd(8'h27);
    chk("ratio", 8'h06, 8'(rat));
    cmd(8'hcf);
    chk("scan", 8'h01, 8'(scn));
    cmd(8'hc7);
    chk("scan", 8'h00, 8'(scn));
    cmd(8'hf5);
    chk("test", 8'h01, 8'(tst));
    cmd(8'he3);
    chk("test", 8'h00, 8'(tst));
  endtask
  task automatic t_pairs();
    cmd(8'h81);
    chk("pending", 8'h01, 8'(pnd));
    dat(8'h55);
    chk("pending", 8'h01, 8'(pnd));
    chk("wbyte", 8'h55, wbyte);
    cmd(8'h2a);
    chk("contrast", 8'h2a, 8'(con));
    chk("power", 8'h07, 8'(pwr));
    chk("pending", 8'h00, 8'(pnd));
    cmd(8'h81);
    cmd(8'hc8);
    chk("contrast", 8'h08, 8'(con));
    chk("scan", 8'h00, 8'(scn));
    cmd(8'h81);
    cmd(8'h20);
    chk("contrast", 8'h20, 8'(con));
    for (int i = 0; i < 4; i++) begin
      cmd(8'had);
      cmd(8'hfc | 8'(i));
      chk("indicator", 8'(i), 8'(ind));
      chk("test", 8'h00, 8'(tst));
    end
    cmd(8'hac);
    chk("indicator", 8'h00, 8'(ind));
    chk("pending", 8'h00, 8'(pnd));
    cmd(8'hd8);
    chk("pending", 8'h01, 8'(pnd));
    cmd(8'he0);
    chk("count", 8'h00, 8'(lcnt));
    chk("rmw", 8'h00, 8'(rmw));
    cmd(8'hd0);
    chk("linerev", 8'h00, 8'(lrv));
    chk("pending", 8'h00, 8'(pnd));
    cmd(8'hdf);
    cmd(8'hff);
    chk("count", 8'h1f, 8'(lcnt));
  endtask
  task automatic t_rmw();
    cmd(8'h11);
    cmd(8'h02);
    cmd(8'he0);
    rdd();
    chk("column", 8'h12, 8'(col));
    dat(8'ha5);
    dat(8'h5a);
    chk("wbyte", 8'h5a, wbyte);
    rdd();
    chk("column", 8'h14, 8'(col));
    chk("rmw", 8'h01, 8'(rmw));
    cmd(8'hee);
    chk("column", 8'h12, 8'(col));
    chk("rmw", 8'h00, 8'(rmw));
    cmd(8'h18);
    cmd(8'h02);
    cmd(8'he0);
    dat(8'h01);
    dat(8'h02);
    chk("column", 8'h83, 8'(col));
    cmd(8'hee);
    chk("column", 8'h82, 8'(col));
    rdd();
    chk("column", 8'h83, 8'(col));
  endtask
  task automatic t_soft();
    cmd(8'h22);
    cmd(8'h81);
    cmd(8'h11);
    cmd(8'had);
    cmd(8'h03);
    cmd(8'hcf);
    cmd(8'hb3);
    cmd(8'h45);
    cmd(8'hbc);
    cmd(8'he0);
    cmd(8'hf0);
    chk("test", 8'h01, 8'(tst));
    chk("page", 8'h03, 8'(pag));
    chk("line", 8'h05, 8'(sln));
    cmd(8'he2);
    chk("ratio", 8'h04, 8'(rat));
    chk("contrast", 8'h20, 8'(con));
    chk("indicator", 8'h00, 8'(ind));
    chk("scan", 8'h00, 8'(scn));
    chk("page", 8'h00, 8'(pag));
    chk("line", 8'h00, 8'(sln));
    chk("column", 8'h00, 8'(col));
    chk("rmw", 8'h00, 8'(rmw));
    chk("test", 8'h00, 8'(tst));
    chk("power", 8'h07, 8'(pwr));
    chk("linerev", 8'h01, 8'(lrv));
    chk("count", 8'h1f, 8'(lcnt));
    dat(8'h20);
    chk("ratio", 8'h04, 8'(rat));
  endtask
  // ====
  // Main sequence and watchdog, far above the roughly 800 cycles used
  initial begin
    hw_reset();
    t_power_ratio();
    t_pairs();
    t_rmw();
    t_soft();
    hw_reset();
    complete_run();
  end
  initial begin
    repeat (8000) @(posedge clk);
    err_total++;
    complete_run();
  end
endmodule
`default_nettype wire
